// File: pkg/hdlc_link_event_pkg.sv
// package: register map, field layout and carriers for the data link event flags
package hdlc_link_event_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [11:0] LINK2_EVENT_FLAGS_INDEX = 12'hb16;
  localparam logic [11:0] LINK2_EVENT_ENABLES_INDEX = 12'hb17;
  localparam logic [11:0] LINK3_EVENT_FLAGS_INDEX = 12'hb26;
  localparam logic [11:0] LINK3_EVENT_ENABLES_INDEX = 12'hb27;

  // ****************************************************************
  // field layout, shared by flag and enable registers
  // ****************************************************************
  localparam int FLAG_IDLE_SEEN = 0;
  localparam int FLAG_ABORT_SEEN = 1;
  localparam int FLAG_FRAME_CHECK_FAIL = 2;
  localparam int FLAG_RECEIVE_END = 3;
  localparam int FLAG_TRANSMIT_END = 4;
  localparam int FLAG_RECEIVE_START = 5;
  localparam int FLAG_TRANSMIT_START = 6;
  localparam int MESSAGE_KIND_BIT = 7;
  localparam int EVENT_COUNT = 7;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [6:0] FLAGS_RESET = 7'h00;
  localparam logic [6:0] ENABLES_RESET = 7'h00;
  localparam logic [31:0] READDATA_RESET = 32'h0000_0000;

  // message kind encoding
  localparam logic BIT_ORIENTED_SIGNALLING = 1'b0;
  localparam logic MESSAGE_ORIENTED_SIGNALLING = 1'b1;

  // ****************************************************************
  // carriers
  // ****************************************************************
  // packed so that bit n of the struct is bit n of the status register
  typedef struct packed {
    logic message_kind;
    logic transmit_start;
    logic receive_start;
    logic transmit_end;
    logic receive_end;
    logic frame_check_fail;
    logic abort_seen;
    logic idle_seen;
  } link_events_type;

  typedef struct packed {
    logic [15:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_request_type;

endpackage : hdlc_link_event_pkg

// File: core/event_flag_bank.sv
// sticky event flags of one data link controller, cleared by a status read
`timescale 1ns/1ps
`default_nettype none
module event_flag_bank (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic [6:0] EVENTS,
  input wire logic CLEAR,
  output logic [6:0] FLAGS
);
  import hdlc_link_event_pkg::*;

  // ****************************************************************
  // flags
  // ****************************************************************
  // a clear drops only what is set now, and an event in that cycle survives
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      FLAGS <= FLAGS_RESET;
    end else if (CLEAR) begin
      FLAGS <= EVENTS;
    end else begin
      FLAGS <= FLAGS | EVENTS;
    end
  end

endmodule : event_flag_bank
`default_nettype wire

// File: core/hdlc_link_event_flags.sv
// event flags, enables and interrupt request of data link controllers two and three
//
// Behaviour
// - link2 receive-end flag sets on a full message or a full receive buffer
// - link2 frame-check flag sets when the last message fails its check sequence
// - link2 abort flag sets on seven consecutive ones
// - link2 idle flag sets on a 0x7e flag octet
// - idle plus receive-end both set signals a complete message
// - flags stay set until a status read, which returns and clears them
// - transmit-start enable gates its interrupt, 1 on, 0 off
// - receive-start enable gates its interrupt, 1 on, 0 off
// - transmit-end enable gates its interrupt, 1 on, 0 off
// - receive-end enable gates its interrupt, 1 on, 0 off
// - frame-check enable gates its interrupt, 1 on, 0 off
// - abort enable gates its interrupt, 1 on, 0 off
// - idle enable gates its interrupt, 1 on, 0 off
// - read-only message kind bit: 0 bit-oriented, 1 message-oriented
// - link3 transmit-start flag sets when sending begins
// - link3 receive-start flag sets when reception begins
// - link3 transmit-end flag sets when sending completes
// - link3 keeps its own receive-end, frame-check, abort and idle flags
`timescale 1ns/1ps
`default_nettype none
module hdlc_link_event_flags (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire hdlc_link_event_pkg::avmm_request_type AVS_REQ,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire hdlc_link_event_pkg::link_events_type LINK2_EVENTS,
  input wire hdlc_link_event_pkg::link_events_type LINK3_EVENTS,
  output logic IRQ,
  output logic LINK2_MESSAGE_DONE,
  output logic LINK3_MESSAGE_DONE
);
  import hdlc_link_event_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // byte address of a register index
  function automatic logic [15:0] reg_addr(input logic [11:0] index);
    reg_addr = {2'b00, index, 2'b00};
  endfunction : reg_addr

  // true when the request targets the register at this index
  function automatic logic reg_hit(input logic [15:0] address, input logic [11:0] index);
    reg_hit = (address == reg_addr(index));
  endfunction : reg_hit

  // any flag with its enable set
  function automatic logic flag_pending(input logic [6:0] flags, input logic [6:0] enables);
    flag_pending = |(flags & enables);
  endfunction : flag_pending

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [6:0] link2_flags;
  logic [6:0] link3_flags;
  logic [6:0] link2_enables;
  logic [6:0] link3_enables;
  logic accept;
  logic read_accept;
  logic write_accept;
  logic clear2;
  logic clear3;
  logic [7:0] next_read_byte;

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // a request is taken in the one cycle that waitrequest is still high
  assign accept = (AVS_REQ.read | AVS_REQ.write) & AVS_WAITREQUEST;
  assign read_accept = accept & AVS_REQ.read;
  assign write_accept = accept & AVS_REQ.write & AVS_REQ.byteenable[0];

  // one wait cycle per access keeps readdata a flop output
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= ~((AVS_REQ.read | AVS_REQ.write) & AVS_WAITREQUEST);
    end
  end

  // ****************************************************************
  // flag banks
  // ****************************************************************
  // the read that returns a status register is the one that clears it
  assign clear2 = read_accept & reg_hit(AVS_REQ.address, LINK2_EVENT_FLAGS_INDEX);
  assign clear3 = read_accept & reg_hit(AVS_REQ.address, LINK3_EVENT_FLAGS_INDEX);

  // link two events land at their own register bit positions
  event_flag_bank link2_bank (
    .CLOCK(CLOCK),
    .ARST_N(ARST_N),
    .EVENTS(LINK2_EVENTS[6:0]),
    .CLEAR(clear2),
    .FLAGS(link2_flags)
  );

  // link three keeps an identical, independent bank
  event_flag_bank link3_bank (
    .CLOCK(CLOCK),
    .ARST_N(ARST_N),
    .EVENTS(LINK3_EVENTS[6:0]),
    .CLEAR(clear3),
    .FLAGS(link3_flags)
  );

  // ****************************************************************
  // enable registers
  // ****************************************************************
  // bit 7 is reserved: not stored, reads zero
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      link2_enables <= ENABLES_RESET;
    end else if (write_accept && reg_hit(AVS_REQ.address, LINK2_EVENT_ENABLES_INDEX)) begin
      link2_enables <= AVS_REQ.writedata[6:0];
    end
  end

  // link three enables, same layout
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      link3_enables <= ENABLES_RESET;
    end else if (write_accept && reg_hit(AVS_REQ.address, LINK3_EVENT_ENABLES_INDEX)) begin
      link3_enables <= AVS_REQ.writedata[6:0];
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // unmapped addresses read as zero; writes to status registers are ignored
  always_comb begin
    next_read_byte = 8'h00;
    if (reg_hit(AVS_REQ.address, LINK2_EVENT_FLAGS_INDEX)) begin
      next_read_byte = {LINK2_EVENTS.message_kind, link2_flags};
    end else if (reg_hit(AVS_REQ.address, LINK2_EVENT_ENABLES_INDEX)) begin
      next_read_byte = {1'b0, link2_enables};
    end else if (reg_hit(AVS_REQ.address, LINK3_EVENT_FLAGS_INDEX)) begin
      next_read_byte = {LINK3_EVENTS.message_kind, link3_flags};
    end else if (reg_hit(AVS_REQ.address, LINK3_EVENT_ENABLES_INDEX)) begin
      next_read_byte = {1'b0, link3_enables};
    end
  end

  // read data stands until the next accepted read
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      AVS_READDATA <= READDATA_RESET;
    end else if (read_accept) begin
      AVS_READDATA <= {24'h000000, next_read_byte};
    end
  end

  // ****************************************************************
  // interrupt and completion outputs
  // ****************************************************************
  // registered, so the request lags its flag by one cycle
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= flag_pending(link2_flags, link2_enables) | flag_pending(link3_flags, link3_enables);
    end
  end

  // idle and receive end together mean the whole message is in
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      LINK2_MESSAGE_DONE <= 1'b0;
      LINK3_MESSAGE_DONE <= 1'b0;
    end else begin
      LINK2_MESSAGE_DONE <= link2_flags[FLAG_RECEIVE_END] & link2_flags[FLAG_IDLE_SEEN];
      LINK3_MESSAGE_DONE <= link3_flags[FLAG_RECEIVE_END] & link3_flags[FLAG_IDLE_SEEN];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);

  property p_link2_receive_end;
    LINK2_EVENTS.receive_end |=> link2_flags[FLAG_RECEIVE_END];
  endproperty
  a_link2_receive_end: assert property (p_link2_receive_end) else $error("link2 receive end not flagged");

  property p_link2_frame_check;
    LINK2_EVENTS.frame_check_fail |=> link2_flags[FLAG_FRAME_CHECK_FAIL];
  endproperty
  a_link2_frame_check: assert property (p_link2_frame_check) else $error("link2 check fail not flagged");

  property p_link2_abort;
    LINK2_EVENTS.abort_seen |=> link2_flags[FLAG_ABORT_SEEN] ##1 (link2_flags[FLAG_ABORT_SEEN] || $past(clear2));
  endproperty
  a_link2_abort: assert property (p_link2_abort) else $error("link2 abort not flagged");

  property p_link2_idle;
    LINK2_EVENTS.idle_seen |=> link2_flags[FLAG_IDLE_SEEN];
  endproperty
  a_link2_idle: assert property (p_link2_idle) else $error("link2 idle not flagged");

  property p_message_done;
    (link2_flags[FLAG_RECEIVE_END] && link2_flags[FLAG_IDLE_SEEN]) |=> LINK2_MESSAGE_DONE;
  endproperty
  a_message_done: assert property (p_message_done) else $error("complete message not signalled");

  property p_flags_hold;
    !clear2 |=> ((link2_flags & $past(link2_flags)) == $past(link2_flags));
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("link2 flag lost without a read");

  property p_read_clears;
    (clear2 && (LINK2_EVENTS[6:0] == 7'h00)) |=> (link2_flags == 7'h00) && (AVS_READDATA[6:0] == $past(link2_flags));
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status read did not return and clear");

  property p_transmit_start_irq;
    (link2_flags[FLAG_TRANSMIT_START] && link2_enables[FLAG_TRANSMIT_START]) |=> IRQ;
  endproperty
  a_transmit_start_irq: assert property (p_transmit_start_irq) else $error("transmit start irq missing");

  property p_receive_start_irq;
    (link2_flags[FLAG_RECEIVE_START] && link2_enables[FLAG_RECEIVE_START]) |=> IRQ;
  endproperty
  a_receive_start_irq: assert property (p_receive_start_irq) else $error("receive start irq missing");

  property p_transmit_end_irq;
    (link2_flags[FLAG_TRANSMIT_END] && link2_enables[FLAG_TRANSMIT_END]) |=> IRQ;
  endproperty
  a_transmit_end_irq: assert property (p_transmit_end_irq) else $error("transmit end irq missing");

  property p_receive_end_irq;
    (link2_flags[FLAG_RECEIVE_END] && link2_enables[FLAG_RECEIVE_END]) |=> IRQ;
  endproperty
  a_receive_end_irq: assert property (p_receive_end_irq) else $error("receive end irq missing");

  property p_frame_check_irq;
    (link2_flags[FLAG_FRAME_CHECK_FAIL] && link2_enables[FLAG_FRAME_CHECK_FAIL]) |=> IRQ;
  endproperty
  a_frame_check_irq: assert property (p_frame_check_irq) else $error("check fail irq missing");

  property p_abort_irq;
    (link2_flags[FLAG_ABORT_SEEN] && link2_enables[FLAG_ABORT_SEEN]) |=> IRQ;
  endproperty
  a_abort_irq: assert property (p_abort_irq) else $error("abort irq missing");

  property p_idle_irq;
    (link2_flags[FLAG_IDLE_SEEN] && link2_enables[FLAG_IDLE_SEEN]) |=> IRQ;
  endproperty
  a_idle_irq: assert property (p_idle_irq) else $error("idle irq missing");

  property p_message_kind;
    clear3 |=> (AVS_READDATA[MESSAGE_KIND_BIT] == $past(LINK3_EVENTS.message_kind));
  endproperty
  a_message_kind: assert property (p_message_kind) else $error("message kind bit wrong");

  property p_link3_transmit_start;
    LINK3_EVENTS.transmit_start |=> link3_flags[FLAG_TRANSMIT_START];
  endproperty
  a_link3_transmit_start: assert property (p_link3_transmit_start) else $error("link3 tx start lost");

  property p_link3_receive_start;
    LINK3_EVENTS.receive_start |=> link3_flags[FLAG_RECEIVE_START];
  endproperty
  a_link3_receive_start: assert property (p_link3_receive_start) else $error("link3 rx start lost");

  property p_link3_transmit_end;
    LINK3_EVENTS.transmit_end |=> link3_flags[FLAG_TRANSMIT_END];
  endproperty
  a_link3_transmit_end: assert property (p_link3_transmit_end) else $error("link3 tx end lost");

  property p_link3_receive_set;
    (LINK3_EVENTS[FLAG_RECEIVE_END:FLAG_IDLE_SEEN] != 4'h0) |=>
      ((link3_flags[FLAG_RECEIVE_END:FLAG_IDLE_SEEN] | ~$past(LINK3_EVENTS[FLAG_RECEIVE_END:FLAG_IDLE_SEEN])) == 4'hf);
  endproperty
  a_link3_receive_set: assert property (p_link3_receive_set) else $error("link3 receive flags lost");

  property p_irq_idle;
    !(flag_pending(link2_flags, link2_enables) || flag_pending(link3_flags, link3_enables)) |=> !IRQ;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq without an enabled flag");

  property p_one_wait;
    (AVS_REQ.read && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer not one cycle after request");

  property p_one_wait_write;
    (AVS_REQ.write && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endproperty
  a_one_wait_write: assert property (p_one_wait_write) else $error("write answer not one cycle after request");

  property p_readdata_hold;
    !read_accept |=> $stable(AVS_READDATA);
  endproperty
  a_readdata_hold: assert property (p_readdata_hold) else $error("read data moved without a read");

  property p_link3_message_done;
    (link3_flags[FLAG_RECEIVE_END] && link3_flags[FLAG_IDLE_SEEN]) |=> LINK3_MESSAGE_DONE;
  endproperty
  a_link3_message_done: assert property (p_link3_message_done) else $error("link3 message not signalled");

  property p_link3_flags_hold;
    !clear3 |=> ((link3_flags & $past(link3_flags)) == $past(link3_flags));
  endproperty
  a_link3_flags_hold: assert property (p_link3_flags_hold) else $error("link3 flag lost without a read");

  property p_link3_read_clears;
    (clear3 && (LINK3_EVENTS[6:0] == 7'h00)) |=>
      (link3_flags == 7'h00) && (AVS_READDATA[6:0] == $past(link3_flags));
  endproperty
  a_link3_read_clears: assert property (p_link3_read_clears) else $error("link3 read did not return and clear");

  property p_set_wins;
    (clear2 && (LINK2_EVENTS[6:0] != 7'h00)) |=> (link2_flags == $past(LINK2_EVENTS[6:0]));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost in the clearing read");

  property p_enable_write;
    (write_accept && reg_hit(AVS_REQ.address, LINK2_EVENT_ENABLES_INDEX)) |=>
      (link2_enables == $past(AVS_REQ.writedata[6:0]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("link2 enables not stored");

  property p_enables_hold;
    !(write_accept && reg_hit(AVS_REQ.address, LINK2_EVENT_ENABLES_INDEX)) |=> $stable(link2_enables);
  endproperty
  a_enables_hold: assert property (p_enables_hold) else $error("link2 enables moved without a write");

  property p_link2_irq;
    flag_pending(link2_flags, link2_enables) |=> IRQ;
  endproperty
  a_link2_irq: assert property (p_link2_irq) else $error("link2 irq missing");

  property p_link3_irq;
    flag_pending(link3_flags, link3_enables) |=> IRQ;
  endproperty
  a_link3_irq: assert property (p_link3_irq) else $error("link3 irq missing");

endmodule : hdlc_link_event_flags
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the data link event flags, enables and interrupt request
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
  import hdlc_link_event_pkg::*;

  // ****************************************************************
  // stimulus and observation signals
  // ****************************************************************
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  avmm_request_type avs_req = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic link2_done;
  logic link3_done;
  logic [6:0] pulse_bits [2] = '{7'h00, 7'h00};
  logic kind_bit [2] = '{1'b0, 1'b0};
  link_events_type link2_events;
  link_events_type link3_events;
  logic [15:0] flag_addr [2];
  logic [15:0] enable_addr [2];
  int err_total = 0;
  int n_tests = 0;
  logic hung = 1'b0;
  logic [31:0] rd;

  // byte addresses are four times the register index
  assign flag_addr[0] = {2'b00, LINK2_EVENT_FLAGS_INDEX, 2'b00};
  assign flag_addr[1] = {2'b00, LINK3_EVENT_FLAGS_INDEX, 2'b00};
  assign enable_addr[0] = {2'b00, LINK2_EVENT_ENABLES_INDEX, 2'b00};
  assign enable_addr[1] = {2'b00, LINK3_EVENT_ENABLES_INDEX, 2'b00};
  assign link2_events = {kind_bit[0], pulse_bits[0]};
  assign link3_events = {kind_bit[1], pulse_bits[1]};

  // 50 mhz clock
  always #10 clock = ~clock;

  hdlc_link_event_flags dut (
    .CLOCK(clock),
    .ARST_N(arst_n),
    .AVS_REQ(avs_req),
    .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest),
    .LINK2_EVENTS(link2_events),
    .LINK3_EVENTS(link3_events),
    .IRQ(irq),
    .LINK2_MESSAGE_DONE(link2_done),
    .LINK3_MESSAGE_DONE(link3_done)
  );

  // ****************************************************************
  // bus and event tasks
  // ****************************************************************
  // one avalon access; entered just after a rising edge, request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [15:0] addr, input logic [31:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    avs_req.address <= addr;
    avs_req.read <= ~wr;
    avs_req.write <= wr;
    avs_req.writedata <= wd;
    avs_req.byteenable <= be;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      err_total++;
      hung = 1'b1;
    end
    rd = avs_readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
    // one idle edge, so no strobe is assigned twice in a time step
    @(posedge clock);
  endtask : bus

  task automatic read_check(input logic [15:0] addr, input logic [31:0] exp);
    bus(1'b0, addr, 32'h0000_0000, 4'hf);
    `CHECK(rd, exp)
  endtask : read_check

  // one-cycle event pulse on link k (0 is link two, 1 is link three)
  task automatic pulse(input int k, input logic [6:0] bits);
    pulse_bits[k] <= bits;
    @(posedge clock);
    pulse_bits[k] <= 7'h00;
  endtask : pulse

  function automatic logic done_of(input int k);
    return (k != 0) ? link3_done : link2_done;
  endfunction : done_of

  task automatic give_verdict;
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  // a wait that ran out of its bound ends the run here
  initial begin
    wait (hung === 1'b1);
    give_verdict();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [6:0] m;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    `CHECK(avs_waitrequest, 1'b1)
    `CHECK(irq, 1'b0)
    for (int k = 0; k < 2; k++) begin
      read_check(flag_addr[k], 32'h0000_0000);
      read_check(enable_addr[k], 32'h0000_0000);
      // enables store bits 6:0 only, bit 7 is reserved
      bus(1'b1, enable_addr[k], 32'hffff_ffff, 4'hf);
      read_check(enable_addr[k], 32'h0000_007f);
      bus(1'b1, enable_addr[k], 32'h0000_0000, 4'he);
      read_check(enable_addr[k], 32'h0000_007f);
      bus(1'b1, enable_addr[k], 32'h0000_0000, 4'hf);
      // flag registers are not writable
      bus(1'b1, flag_addr[k], 32'h0000_00ff, 4'hf);
      read_check(flag_addr[k], 32'h0000_0000);
    end
    // unmapped place reads zero and swallows writes
    bus(1'b1, 16'h0000, 32'h0000_00ff, 4'hf);
    read_check(16'h0000, 32'h0000_0000);
    read_check(enable_addr[0], 32'h0000_0000);

    // every event bit: masked by its own enable with all other enables set, then enabled alone
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 7; i++) begin
        m = 7'h01 << i;
        bus(1'b1, enable_addr[k], {25'h0, ~m}, 4'hf);
        pulse(k, m);
        repeat (2) @(posedge clock);
        `CHECK(irq, 1'b0)
        `CHECK(done_of(k), 1'b0)
        read_check(flag_addr[k], {25'h0, m});
        bus(1'b1, enable_addr[k], {25'h0, m}, 4'hf);
        pulse(k, m);
        repeat (2) @(posedge clock);
        `CHECK(irq, 1'b1)
        read_check(flag_addr[k], {25'h0, m});
        `CHECK(irq, 1'b0)
        read_check(flag_addr[k], 32'h0000_0000);
      end
      bus(1'b1, enable_addr[k], 32'h0000_0000, 4'hf);
      // idle together with receive end marks a complete message
      pulse(k, 7'h09);
      repeat (2) @(posedge clock);
      `CHECK(done_of(k), 1'b1)
      read_check(flag_addr[k], 32'h0000_0009);
      `CHECK(done_of(k), 1'b0)
      // message kind is a live read-only level, untouched by the read clear
      kind_bit[k] <= MESSAGE_ORIENTED_SIGNALLING;
      @(posedge clock);
      read_check(flag_addr[k], 32'h0000_0080);
      read_check(flag_addr[k], 32'h0000_0080);
      kind_bit[k] <= BIT_ORIENTED_SIGNALLING;
      @(posedge clock);
    end

    // host picks up transmit start, then has the next buffer in before transmit end
    pulse(1, 7'h40);
    read_check(flag_addr[1], 32'h0000_0040);
    pulse(1, 7'h10);
    read_check(flag_addr[1], 32'h0000_0010);

    // event in the cycle of the clearing read survives it
    fork
      read_check(flag_addr[0], 32'h0000_0000);
      pulse(0, 7'h01);
    join
    read_check(flag_addr[0], 32'h0000_0001);
    give_verdict();
  end
endmodule : tb_top
`undef CHECK
`default_nettype wire
